//--- rtl/cpm_regs.svh
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index, low six bits decoded)
// ----------------------------------------
`define CPM_IDX_CLK   32'h0500_0000
`define CPM_IDX_RST   32'h0500_0001
`define CPM_IDX_BOR   32'h5000_0002
`define CPM_IDX_WAKE  32'h5000_0004
`define CPM_IDX_MISC  32'h5000_0005
`define CPM_IDX_MON   32'h5000_0006
`define CPM_IDX_VREG1 32'h5001_800D
`define CPM_IDX_VREG2 32'h5001_800F
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPM_CLK_RST   8'h15
`define CPM_RST_RST   8'h01
`define CPM_VREG1_RST 8'h04
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPM_CKD_LSB   6
`define CPM_RC_OSC_ACTIVE_FLAG     4
`define CPM_XO_EN     3
`define CPM_RC_EN     2
`define CPM_HARDWARE_RESET_TRIGGER     7
`define CPM_SOFTWARE_RESET_TRIGGER     6
`define CPM_DEEP      5
`define CPM_BROWNOUT_INDICATOR     1
`define CPM_POWER_ON_FLAG      0
`define CPM_BROWNOUT_ENABLE     7
`define CPM_BROWNOUT_RESET_ENABLE    3
`define CPM_BROWNOUT_IRQ_ENABLE    2
`define CPM_SERFAST   7
`define CPM_PRB_A_LSB 3
`define CPM_IO_PUMP   7
`define CPM_MON_IE    0
`define CPM_MON_FAIL  1
// ----------------------------------------
// timing
// ----------------------------------------
`define CPM_CLK_MHZ      50
`define CPM_RST_PULSE_NS 100
`define CPM_RST_PULSE_CYC ((`CPM_RST_PULSE_NS * `CPM_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/cpm_pkg.sv
package cpm_pkg;
    // clock source codes as seen in the select field
    typedef enum logic [1:0] {
        SRC_AUX  = 2'b00,
        SRC_RC   = 2'b01,
        SRC_XO   = 2'b10,
        SRC_NONE = 2'b11
    } cpm_src_e;
    // power state of the cpu
    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} cpm_pwr_e;
    // whole block state
    typedef struct packed {
        logic [1:0]  clock_divider_field;
        logic        xo_en;
        logic        rc_en;
        cpm_src_e    sel;
        logic        power_on_flag;
        logic        brownout_indicator;
        cpm_pwr_e    pwr;
        logic        bor_en;
        logic        bor_rst_en;
        logic        bor_irq_en;
        logic [1:0]  bor_lvl;
        logic        serfast;
        logic [2:0]  prb_a_sel;
        logic [2:0]  prb_b_sel;
        logic [7:0]  wake;
        logic        io_pump;
        logic [4:0]  trim;
        logic [6:0]  vreg2;
        logic        mon_ie;
        logic        mon_fail;
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [5:0]  flt;
        logic [2:0]  div_cnt;
        logic [16:0] wk_cnt;
        logic [2:0]  rst_cnt;
        logic        bor_prev;
        logic        pready;
        logic        pslverr;
        logic [7:0]  prdata;
        logic        sysclk_en;
        logic        ser_en;
        logic        periph_rst;
        logic        cpu_halt;
        logic        timer_stop;
        logic        aux_en;
        logic        bor_irq;
        logic        mon_irq;
        logic        prb_a;
        logic        prb_b;
    } cpm_state_s;
endpackage

//--- rtl/cpm_top.sv
`timescale 1ns/10ps
`include "cpm_regs.svh"
// Functional notes
// - auxiliary oscillator always on, never software-disabled
// - divider codes divide system clock by 1/2/4/8
// - read-only bit reports RC oscillator activity
// - crystal enable bit starts/stops crystal oscillator
// - RC enable bit starts/stops RC oscillator
// - source select: aux, RC, crystal; 11 unused
// - power-on reset starts on RC, reads 0x15
// - enableable clock-monitor interrupt on source failure
// - hardware reset: peripherals reset, aux clock only
// - software reset keeps clock and brownout setup
// - brownout indicator reads 1 after a brownout
// - power flag set on power-on and hardware-type reset, write-0 clears
// - brownout enable switches detector on and off
// - brownout reset and interrupt enabled independently
// - two-bit field selects brownout level
// - deep sleep halts cpu and stops timers
// - deep sleep exits only through a reset
// - sleep halts cpu, interrupt or reset wakes
// - one charge-pump enable bit per supply
// - wake period is mantissa times 2^(exp+1), exponent clamped at 12
module cpm_top #(
    parameter int WK_W = 17
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_RC_OK,
    input  wire logic        I_XO_OK,
    input  wire logic        I_BROWNOUT,
    input  wire logic        I_FUSE,
    input  wire logic        I_ADC_CLK,
    input  wire logic        I_PUMP_CLK,
    input  wire logic        I_SLEEP_REQ,
    input  wire logic        I_WAKE_LOCAL,
    input  wire logic        I_WAKE_IRQ,
    output cpm_pkg::cpm_src_e O_SRC_SEL,
    output logic             O_AUX_EN,
    output logic             O_RC_EN,
    output logic             O_XO_EN,
    output logic             O_SYSCLK_EN,
    output logic             O_SER_EN,
    output logic             O_PERIPH_RST,
    output logic             O_CPU_HALT,
    output logic             O_TIMER_STOP,
    output logic             O_BOR_EN,
    output logic      [1:0]  O_BOR_LEVEL,
    output logic             O_BOR_IRQ,
    output logic             O_CLKMON_IRQ,
    output logic      [4:0]  O_PUMP_EN,
    output logic             O_PROBE_A,
    output logic             O_PROBE_B
);
    import cpm_pkg::*;

    cpm_state_s st_r;
    cpm_state_s st_nxt;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // register select: only the low six index bits reach the decoder
    function automatic logic hit(input logic [7:0] a, input logic [31:0] idx);
        return a[7:2] == idx[5:0];
    endfunction

    // last divider count for each divide code
    function automatic logic [2:0] div_last(input logic [1:0] c);
        return 3'((4'd1 << c) - 4'd1);
    endfunction

    // wake period in system clock ticks; exponent clamps at 12
    function automatic logic [WK_W-1:0] wake_len(input logic [7:0] w);
        logic [3:0] e;
        e = (w[3:0] > 4'd12) ? 4'd12 : w[3:0];
        return WK_W'(w[7:4]) << (e + 4'd1);
    endfunction

    // ----------------------------------------
    // combinational view
    // ----------------------------------------
    logic        acc;
    logic        done;
    logic        wr;
    logic [7:0]  wd;
    logic        rc_act;
    logic        hw_rst;
    logic        sw_rst;
    logic        bor_hit;
    logic        bor_rst;
    logic        wake_hit;
    logic        deep_wake;
    logic        rst_any;
    logic        hw_type;
    logic        fail;
    logic        tick;
    logic        rd_hit;
    logic [7:0]  rd;

    always_comb begin
        st_nxt = st_r;
        acc = I_PSEL & I_PENABLE;
        done = acc & st_r.pready;
        wr = done & I_PWRITE & ~st_r.pslverr;
        wd = I_PWDATA[7:0];

        // three-stage pin capture; a change counts once stages two and three agree
        st_nxt.s1 = {I_PUMP_CLK, I_ADC_CLK, I_FUSE, I_BROWNOUT, I_XO_OK, I_RC_OK};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.flt = (st_r.s2 & st_r.s3) | (st_r.flt & (st_r.s2 ^ st_r.s3));
        rc_act = st_r.flt[0];

        // event decode
        hw_rst = wr && hit(I_PADDR, `CPM_IDX_RST) && wd[`CPM_HARDWARE_RESET_TRIGGER];
        sw_rst = wr && hit(I_PADDR, `CPM_IDX_RST) && wd[`CPM_SOFTWARE_RESET_TRIGGER];
        bor_hit = st_r.bor_en & st_r.flt[2];
        bor_rst = bor_hit & ~st_r.bor_prev & st_r.bor_rst_en;
        st_nxt.bor_prev = bor_hit;
        wake_hit = (st_r.wake[7:4] != 4'd0) && (st_r.wk_cnt >= wake_len(st_r.wake));
        deep_wake = (st_r.pwr == PWR_DEEP) && (I_WAKE_LOCAL || wake_hit);
        hw_type = hw_rst | bor_rst;
        rst_any = hw_type | sw_rst | deep_wake;
        // selected source lost; a crystal selected before it settles trips this too
        fail = ((st_r.sel == SRC_RC) && !st_r.flt[0]) || ((st_r.sel == SRC_XO) && !st_r.flt[1]);

        // read mux, address chain
        rd_hit = 1'b1;
        if (hit(I_PADDR, `CPM_IDX_CLK)) begin
            rd = {st_r.clock_divider_field, 1'b0, rc_act, st_r.xo_en, st_r.rc_en, st_r.sel};
        end else if (hit(I_PADDR, `CPM_IDX_RST)) begin
            rd = {2'b00, st_r.pwr == PWR_DEEP, 3'b000, st_r.brownout_indicator, st_r.power_on_flag};
        end else if (hit(I_PADDR, `CPM_IDX_BOR)) begin
            rd = {st_r.bor_en, 3'b000, st_r.bor_rst_en, st_r.bor_irq_en, st_r.bor_lvl};
        end else if (hit(I_PADDR, `CPM_IDX_WAKE)) begin
            rd = st_r.wake;
        end else if (hit(I_PADDR, `CPM_IDX_MISC)) begin
            rd = {st_r.serfast, 1'b0, st_r.prb_a_sel, st_r.prb_b_sel};
        end else if (hit(I_PADDR, `CPM_IDX_MON)) begin
            rd = {6'h00, st_r.mon_fail, st_r.mon_ie};
        end else if (hit(I_PADDR, `CPM_IDX_VREG1)) begin
            rd = {st_r.io_pump, 2'b00, st_r.trim};
        end else if (hit(I_PADDR, `CPM_IDX_VREG2)) begin
            rd = {1'b0, st_r.vreg2};
        end else begin
            rd = 8'h00;
            rd_hit = 1'b0;
        end

        // apb: one wait state, answer registered in the first access cycle
        st_nxt.pready = acc & ~st_r.pready;
        if (acc && !st_r.pready) begin
            st_nxt.prdata = I_PWRITE ? 8'h00 : rd;
            st_nxt.pslverr = ~rd_hit;
        end else if (done) begin
            st_nxt.prdata = 8'h00;
            st_nxt.pslverr = 1'b0;
        end

        // register writes
        if (wr && hit(I_PADDR, `CPM_IDX_CLK)) begin
            st_nxt.clock_divider_field = wd[`CPM_CKD_LSB +: 2];
            st_nxt.xo_en = wd[`CPM_XO_EN];
            st_nxt.rc_en = wd[`CPM_RC_EN];
            if (wd[1:0] != SRC_NONE) begin
                st_nxt.sel = cpm_src_e'(wd[1:0]);
            end
        end else if (wr && hit(I_PADDR, `CPM_IDX_RST)) begin
            if (!wd[`CPM_POWER_ON_FLAG]) begin
                st_nxt.power_on_flag = 1'b0;
            end
        end else if (wr && hit(I_PADDR, `CPM_IDX_BOR)) begin
            st_nxt.bor_en = wd[`CPM_BROWNOUT_ENABLE];
            st_nxt.bor_rst_en = wd[`CPM_BROWNOUT_RESET_ENABLE];
            st_nxt.bor_irq_en = wd[`CPM_BROWNOUT_IRQ_ENABLE];
            st_nxt.bor_lvl = wd[1:0];
        end else if (wr && hit(I_PADDR, `CPM_IDX_WAKE)) begin
            st_nxt.wake = wd;
        end else if (wr && hit(I_PADDR, `CPM_IDX_MISC)) begin
            st_nxt.serfast = wd[`CPM_SERFAST];
            st_nxt.prb_a_sel = wd[`CPM_PRB_A_LSB +: 3];
            st_nxt.prb_b_sel = wd[2:0];
        end else if (wr && hit(I_PADDR, `CPM_IDX_MON)) begin
            st_nxt.mon_ie = wd[`CPM_MON_IE];
            if (wd[`CPM_MON_FAIL]) begin
                st_nxt.mon_fail = 1'b0;
            end
        end else if (wr && hit(I_PADDR, `CPM_IDX_VREG1)) begin
            st_nxt.io_pump = wd[`CPM_IO_PUMP];
            st_nxt.trim = wd[4:0];
        end else if (wr && hit(I_PADDR, `CPM_IDX_VREG2)) begin
            st_nxt.vreg2 = wd[6:0];
        end

        // clock failure: back to RC; the flag is set after the clear so it wins
        if (fail) begin
            st_nxt.sel = SRC_RC;
            st_nxt.rc_en = 1'b1;
            st_nxt.mon_fail = 1'b1;
        end
        // hardware-type reset: aux clock only, brownout setup left alone
        if (hw_type) begin
            st_nxt.sel = SRC_AUX;
            st_nxt.xo_en = 1'b0;
            st_nxt.rc_en = 1'b0;
            st_nxt.power_on_flag = 1'b1;
        end
        // brownout memory is cleared only by power-on
        if (bor_hit) begin
            st_nxt.brownout_indicator = 1'b1;
        end

        // system clock divider as a one-cycle enable
        tick = st_r.div_cnt >= div_last(st_r.clock_divider_field);
        st_nxt.div_cnt = tick ? 3'd0 : st_r.div_cnt + 3'd1;
        st_nxt.sysclk_en = tick;
        st_nxt.ser_en = st_r.serfast | tick;

        // power state
        case (st_r.pwr)
            PWR_RUN: begin
                if (wr && hit(I_PADDR, `CPM_IDX_RST) && wd[`CPM_DEEP]) begin
                    st_nxt.pwr = PWR_DEEP;
                end else if (I_SLEEP_REQ) begin
                    st_nxt.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (I_WAKE_IRQ) begin
                    st_nxt.pwr = PWR_RUN;
                end
            end
            default: begin
                st_nxt.pwr = PWR_DEEP;
            end
        endcase
        if (rst_any) begin
            st_nxt.pwr = PWR_RUN;
        end

        // wake timer counts system ticks only while in deep sleep
        if (st_r.pwr != PWR_DEEP) begin
            st_nxt.wk_cnt = '0;
        end else if (tick && !wake_hit) begin
            st_nxt.wk_cnt = st_r.wk_cnt + WK_W'(1);
        end

        // peripheral reset pulse; a new request restarts it
        if (rst_any) begin
            st_nxt.rst_cnt = 3'(`CPM_RST_PULSE_CYC);
        end else if (st_r.rst_cnt != 3'd0) begin
            st_nxt.rst_cnt = st_r.rst_cnt - 3'd1;
        end
        st_nxt.periph_rst = st_nxt.rst_cnt != 3'd0;

        // registered outputs
        st_nxt.cpu_halt = st_nxt.pwr != PWR_RUN;
        st_nxt.timer_stop = st_nxt.pwr == PWR_DEEP;
        st_nxt.aux_en = 1'b1;
        st_nxt.bor_irq = bor_hit & st_r.bor_irq_en;
        st_nxt.mon_irq = st_nxt.mon_fail & st_nxt.mon_ie;

        // debug probes
        case (st_r.prb_a_sel)
            3'd1: st_nxt.prb_a = st_r.aux_en;
            3'd2: st_nxt.prb_a = st_r.flt[0];
            3'd3: st_nxt.prb_a = st_r.flt[1];
            3'd5: st_nxt.prb_a = st_r.flt[3];
            3'd6: st_nxt.prb_a = st_r.periph_rst & st_r.bor_rst_en;
            default: st_nxt.prb_a = 1'b0;
        endcase
        case (st_r.prb_b_sel)
            3'd1: st_nxt.prb_b = 1'b1;
            3'd2: st_nxt.prb_b = st_r.sysclk_en;
            3'd3: st_nxt.prb_b = st_r.ser_en;
            3'd4: st_nxt.prb_b = st_r.flt[4];
            3'd5: st_nxt.prb_b = st_r.flt[3];
            3'd6: st_nxt.prb_b = st_r.flt[5];
            default: st_nxt.prb_b = 1'b0;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // power-on starts from RC, clock register reads back its reset value
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            st_r <= '0;
            st_r.clock_divider_field <= 2'(`CPM_CLK_RST >> `CPM_CKD_LSB);
            st_r.rc_en <= 1'(`CPM_CLK_RST >> `CPM_RC_EN);
            st_r.sel <= SRC_RC;
            st_r.power_on_flag <= 1'(`CPM_RST_RST);
            st_r.trim <= 5'(`CPM_VREG1_RST);
            st_r.pwr <= PWR_RUN;
            st_r.aux_en <= 1'b1;
            st_r.s1 <= 6'h01;
            st_r.s2 <= 6'h01;
            st_r.s3 <= 6'h01;
            st_r.flt <= 6'h01;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign O_PRDATA = {24'h00_0000, st_r.prdata};
    assign O_PREADY = st_r.pready;
    assign O_PSLVERR = st_r.pslverr;
    assign O_SRC_SEL = st_r.sel;
    assign O_AUX_EN = st_r.aux_en;
    assign O_RC_EN = st_r.rc_en;
    assign O_XO_EN = st_r.xo_en;
    assign O_SYSCLK_EN = st_r.sysclk_en;
    assign O_SER_EN = st_r.ser_en;
    assign O_PERIPH_RST = st_r.periph_rst;
    assign O_CPU_HALT = st_r.cpu_halt;
    assign O_TIMER_STOP = st_r.timer_stop;
    assign O_BOR_EN = st_r.bor_en;
    assign O_BOR_LEVEL = st_r.bor_lvl;
    assign O_BOR_IRQ = st_r.bor_irq;
    assign O_CLKMON_IRQ = st_r.mon_irq;
    assign O_PUMP_EN = {st_r.io_pump, st_r.vreg2[3:0]};
    assign O_PROBE_A = st_r.prb_a;
    assign O_PROBE_B = st_r.prb_b;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    a_aux_always_on: assert property (O_AUX_EN)
        else $error("aux oscillator enable dropped");
    a_div_by_eight: assert property (st_r.sysclk_en && st_r.clock_divider_field == 2'b11 |=>
        (!st_r.sysclk_en || st_r.clock_divider_field != 2'b11) [*6])
        else $error("divide by eight tick too early");
    a_rc_osc_active_flag_filter: assert property (st_r.s2[0] == st_r.s3[0] |=>
        st_r.flt[0] == $past(st_r.s3[0]))
        else $error("rc monitor not following agreed input");
    a_sel_code_unused: assert property (wr && hit(I_PADDR, `CPM_IDX_CLK) && wd[1:0] == 2'b11
        && !fail && !hw_type |=> $stable(st_r.sel))
        else $error("unused select code changed source");
    a_fail_fallback: assert property (fail && !hw_type |=> st_r.sel == SRC_RC && st_r.rc_en)
        else $error("no fallback to rc on failure");
    a_hw_reset_clk: assert property (hw_rst |=> st_r.sel == SRC_AUX && !st_r.xo_en
        && !st_r.rc_en && st_r.power_on_flag && $stable(st_r.bor_lvl))
        else $error("hardware reset clock state wrong");
    a_sw_reset_keep: assert property (sw_rst && !hw_rst && !fail |=>
        $stable(st_r.sel) && $stable(st_r.clock_divider_field) ##0 st_r.periph_rst [*5])
        else $error("software reset disturbed clocks or pulse short");
    a_deep_only_reset: assert property (st_r.pwr == PWR_DEEP && !rst_any |=>
        st_r.pwr == PWR_DEEP && O_TIMER_STOP && O_CPU_HALT)
        else $error("deep sleep left without reset");
    a_power_on_flag_clear: assert property (wr && hit(I_PADDR, `CPM_IDX_RST) && !wd[0] && !hw_type
        |=> !st_r.power_on_flag)
        else $error("power flag not cleared");
    a_bor_irq_path: assert property (bor_hit && st_r.bor_irq_en |=> O_BOR_IRQ)
        else $error("brownout interrupt missing");
    a_sleep_wake: assert property (st_r.pwr == PWR_SLEEP && I_WAKE_IRQ |=>
        st_r.pwr == PWR_RUN ##1 !O_CPU_HALT)
        else $error("sleep not left on interrupt");
endmodule

//--- dv/cpm_top_tb.sv
`timescale 1ns/10ps
`include "cpm_regs.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; $display("CHECK FAILED %s exp=%h got=%h", nm, ex, gt); end end
module cpm_top_tb;
    import cpm_pkg::*;
    logic        I_CLK, I_RESET, I_PSEL, I_PENABLE, I_PWRITE;
    logic [7:0]  I_PADDR;
    logic [31:0] I_PWDATA, O_PRDATA;
    logic        O_PREADY, O_PSLVERR, I_RC_OK, I_XO_OK, I_BROWNOUT, I_SLEEP_REQ, I_WAKE_LOCAL, I_WAKE_IRQ;
    logic        O_AUX_EN, O_RC_EN, O_XO_EN, O_SYSCLK_EN, O_SER_EN, O_PERIPH_RST, O_CPU_HALT, O_TIMER_STOP;
    logic        O_BOR_EN, O_BOR_IRQ, O_CLKMON_IRQ, O_PROBE_A, O_PROBE_B;
    logic [1:0]  O_BOR_LEVEL;
    logic [4:0]  O_PUMP_EN;
    cpm_src_e    O_SRC_SEL;
    int          miscompares, n_tests, k, c, i;
    logic [7:0]  rd, d;
    logic        er;
    // ----------------------------------------
    // reference model: one word per bus slot, slot 3 is an unmapped hole
    // ----------------------------------------
    int          mdl[8] = '{'h15, 'h01, 0, 0, 0, 0, 'h04, 0};
    int          msk[8] = '{0, 0, 'h8F, 0, 'hFF, 'hBF, 'h9F, 'h7F};
    logic [31:0] ids[8] = '{`CPM_IDX_CLK, `CPM_IDX_RST, `CPM_IDX_BOR, 32'h0000_0003,
                            `CPM_IDX_WAKE, `CPM_IDX_MISC, `CPM_IDX_VREG1, `CPM_IDX_VREG2};

    // probe source pins stay quiet; only the constant probe-B code and the aux-enable probe-A code are observed
    cpm_top uut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
        .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
        .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_RC_OK(I_RC_OK), .I_XO_OK(I_XO_OK),
        .I_BROWNOUT(I_BROWNOUT), .I_FUSE(1'b0), .I_ADC_CLK(1'b0), .I_PUMP_CLK(1'b0),
        .I_SLEEP_REQ(I_SLEEP_REQ), .I_WAKE_LOCAL(I_WAKE_LOCAL), .I_WAKE_IRQ(I_WAKE_IRQ),
        .O_SRC_SEL(O_SRC_SEL), .O_AUX_EN(O_AUX_EN), .O_RC_EN(O_RC_EN), .O_XO_EN(O_XO_EN),
        .O_SYSCLK_EN(O_SYSCLK_EN), .O_SER_EN(O_SER_EN), .O_PERIPH_RST(O_PERIPH_RST),
        .O_CPU_HALT(O_CPU_HALT), .O_TIMER_STOP(O_TIMER_STOP), .O_BOR_EN(O_BOR_EN),
        .O_BOR_LEVEL(O_BOR_LEVEL), .O_BOR_IRQ(O_BOR_IRQ), .O_CLKMON_IRQ(O_CLKMON_IRQ),
        .O_PUMP_EN(O_PUMP_EN), .O_PROBE_A(O_PROBE_A), .O_PROBE_B(O_PROBE_B));

    // ----------------------------------------
    // bus and wait helpers
    // ----------------------------------------
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] ix, input logic [7:0] wd);
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE  <= w;
        I_PADDR   <= {ix[5:0], 2'b00};
        I_PWDATA  <= {24'h00_0000, wd};
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        for (k = 0; k < 20 && O_PREADY !== 1'b1; k++) @(posedge I_CLK);
        if (k == 20) begin
            miscompares++;
            summarize();
        end
        rd = O_PRDATA[7:0];
        er = O_PSLVERR;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    // bounded wait for a level; a miss is a mismatch, never a hang
    task automatic wt(ref logic s, input logic v, input int n, input string nm);
        for (c = 0; c < n && s !== v; c++) @(posedge I_CLK);
        `CHK(nm, v, s)
    endtask
    // peripheral reset must stand exactly five cycles
    task automatic plen(input string nm);
        wt(O_PERIPH_RST, 1'b1, 8, nm);
        for (c = 0; c < 20 && O_PERIPH_RST === 1'b1; c++) @(posedge I_CLK);
        `CHK(nm, 5, c)
    endtask
    // one-cycle pulse: 0 sleep-wake irq, 1 local wake, 2 sleep request
    task automatic pulse(input int n);
        if (n == 0) begin
            I_WAKE_IRQ <= 1'b1;
        end else if (n == 1) begin
            I_WAKE_LOCAL <= 1'b1;
        end else begin
            I_SLEEP_REQ <= 1'b1;
        end
        @(posedge I_CLK);
        {I_WAKE_IRQ, I_WAKE_LOCAL, I_SLEEP_REQ} <= 3'b000;
    endtask
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        I_CLK = 1'b0;
        forever #10 I_CLK = ~I_CLK;
    end
    // the whole run is far below this bound, so reaching it means a hang
    initial begin
        repeat (100000) @(posedge I_CLK);
        miscompares++;
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {I_PSEL, I_PENABLE, I_PWRITE, I_BROWNOUT, I_SLEEP_REQ, I_WAKE_LOCAL, I_WAKE_IRQ, I_XO_OK} = '0;
        I_PADDR = '0;
        I_PWDATA = '0;
        I_RESET = 1'b1;
        I_RC_OK = 1'b1;
        void'($urandom(32'hb1e8_0f7d));
        repeat (12) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(posedge I_CLK);
        `CHK("src", SRC_RC, O_SRC_SEL)
        `CHK("aux", 1'b1, O_AUX_EN)
        for (i = 0; i < 8; i++) begin
            apb(0, ids[i], 8'h00);
            `CHK("reset value", mdl[i][7:0], rd)
            `CHK("slverr", i == 3, er)
        end
        for (i = 2; i < 8; i++) begin
            d = 8'($urandom());
            apb(1, ids[i], d);
            mdl[i] = d & msk[i];
            apb(0, ids[i], 8'h00);
            `CHK("rw", mdl[i][7:0], rd)
        end
        `CHK("pump", {mdl[6][7], mdl[7][3:0]}, O_PUMP_EN)
        `CHK("bor en", mdl[2][7], O_BOR_EN)
        `CHK("bor lvl", mdl[2][1:0], O_BOR_LEVEL)
        $display("test registers done");
        // divider codes; bit4 written as 0 must still read 1
        for (i = 0; i < 4; i++) begin
            apb(1, ids[0], 8'(i << 6) | 8'h05);
            repeat (2) @(posedge I_CLK);
            c = 0;
            repeat (32) begin
                @(posedge I_CLK);
                c += int'(O_SYSCLK_EN === 1'b1);
            end
            `CHK("div", 32 >> i, c)
            apb(0, ids[0], 8'h00);
            `CHK("clk reg", 8'(i << 6) | 8'h15, rd)
        end
        apb(1, ids[0], 8'h04);
        apb(1, ids[0], 8'h07);
        repeat (2) @(posedge I_CLK);
        `CHK("sel aux", SRC_AUX, O_SRC_SEL)
        apb(0, ids[0], 8'h00);
        `CHK("sel 11", 8'h14, rd)
        $display("test divider done");
        // crystal selected while not yet running must fall back to rc
        apb(1, `CPM_IDX_MON, 8'h01);
        apb(1, ids[0], 8'h0E);
        wt(O_CLKMON_IRQ, 1'b1, 8, "mon irq");
        `CHK("fallback", SRC_RC, O_SRC_SEL)
        apb(1, `CPM_IDX_MON, 8'h03);
        wt(O_CLKMON_IRQ, 1'b0, 4, "mon clr");
        I_XO_OK <= 1'b1;
        repeat (6) @(posedge I_CLK);
        apb(1, ids[0], 8'h0A);
        repeat (8) @(posedge I_CLK);
        `CHK("xo sel", SRC_XO, O_SRC_SEL)
        `CHK("xo on", 1'b1, O_XO_EN)
        `CHK("rc off", 1'b0, O_RC_EN)
        apb(1, ids[0], 8'h05);
        repeat (2) @(posedge I_CLK);
        `CHK("xo off", 1'b0, O_XO_EN)
        `CHK("rc on", 1'b1, O_RC_EN)
        $display("test sources done");
        apb(1, ids[1], 8'h40);
        plen("sw rst");
        apb(0, ids[0], 8'h00);
        `CHK("sw clk kept", 8'h15, rd)
        apb(0, ids[2], 8'h00);
        `CHK("sw bor kept", mdl[2][7:0], rd)
        apb(1, ids[1], 8'h00);
        apb(1, ids[1], 8'h01);
        apb(0, ids[1], 8'h00);
        `CHK("por clear", 8'h00, rd)
        apb(1, ids[1], 8'h80);
        plen("hw rst");
        apb(0, ids[0], 8'h00);
        `CHK("hw clk", 4'h0, rd[3:0])
        `CHK("hw src", SRC_AUX, O_SRC_SEL)
        `CHK("aux", 1'b1, O_AUX_EN)
        apb(0, ids[1], 8'h00);
        `CHK("por set", 8'h01, rd)
        apb(0, ids[2], 8'h00);
        `CHK("hw bor kept", mdl[2][7:0], rd)
        apb(1, ids[0], 8'h05);
        $display("test resets done");
        // deep sleep ignores a plain interrupt and leaves on a local wake
        apb(1, ids[4], 8'h00);
        apb(1, ids[1], 8'h20);
        wt(O_CPU_HALT, 1'b1, 4, "deep halt");
        `CHK("timer stop", 1'b1, O_TIMER_STOP)
        apb(0, ids[1], 8'h00);
        `CHK("deep read", 8'h20, rd & 8'h20)
        pulse(0);
        repeat (20) @(posedge I_CLK);
        `CHK("deep stays", 1'b1, O_CPU_HALT)
        pulse(1);
        plen("deep wake");
        `CHK("run", 1'b0, O_CPU_HALT)
        // mantissa 2, exponent 3, divide by 2: 2 * 2^4 * 2 cycles
        apb(1, ids[0], 8'h45);
        apb(1, ids[4], 8'h23);
        apb(1, ids[1], 8'h20);
        wt(O_CPU_HALT, 1'b1, 4, "deep halt");
        wt(O_CPU_HALT, 1'b0, 200, "timer wake");
        k = (2 << (3 + 1)) * 2;
        `CHK("wake time", 1'b1, c > k - 8 && c < k + 8)
        apb(1, ids[4], 8'h00);
        repeat (8) @(posedge I_CLK);
        pulse(2);
        wt(O_CPU_HALT, 1'b1, 4, "sleep");
        `CHK("timers run", 1'b0, O_TIMER_STOP)
        pulse(0);
        wt(O_CPU_HALT, 1'b0, 4, "sleep wake");
        $display("test power modes done");
        // interrupt only, then reset only
        apb(1, ids[2], 8'h84);
        I_BROWNOUT <= 1'b1;
        wt(O_BOR_IRQ, 1'b1, 8, "bor irq");
        `CHK("no bor rst", 1'b0, O_PERIPH_RST)
        apb(0, ids[1], 8'h00);
        `CHK("brownout_indicator", 1'b1, rd[1])
        I_BROWNOUT <= 1'b0;
        apb(1, ids[2], 8'h88);
        repeat (6) @(posedge I_CLK);
        I_BROWNOUT <= 1'b1;
        plen("bor rst");
        `CHK("bor irq off", 1'b0, O_BOR_IRQ)
        apb(1, ids[5], 8'h89);
        repeat (2) @(posedge I_CLK);
        `CHK("probe b", 1'b1, O_PROBE_B)
        `CHK("probe a", 1'b1, O_PROBE_A)
        `CHK("ser full", 1'b1, O_SER_EN)
        apb(1, ids[5], 8'h00);
        repeat (2) @(posedge I_CLK);
        `CHK("probe a off", 1'b0, O_PROBE_A)
        `CHK("probe b off", 1'b0, O_PROBE_B)
        $display("test brownout done");
        summarize();
    end
endmodule
